// ==== shared/umsil_defines.vh ====
`ifndef UMSIL_DEFINES_VH
`define UMSIL_DEFINES_VH
`define UMSIL_ADR_STATUS 4'h0
`define UMSIL_ADR_IEN 4'h4
`define UMSIL_ADR_ID 4'h8
`define UMSIL_ADR_MCTL 4'hC
`define UMSIL_MCTL_LOOP 4
`define UMSIL_EFR_WEN 4
`define UMSIL_IEN_RESET 8'h00
`define UMSIL_MCTL_RESET 5'h00
`define UMSIL_ID_NONE 5'h00
`define UMSIL_ID_LINE 5'h03
`define UMSIL_ID_TOUT 5'h06
`define UMSIL_ID_RX 5'h02
`define UMSIL_ID_TX 5'h01
`define UMSIL_ID_MODEM 5'h00
`define UMSIL_ID_XOFF 5'h08
`define UMSIL_ID_FLOW 5'h10
`endif

// ==== core/umsil_modem_sync.v ====
`timescale 1ns/1ns
`include "umsil_defines.vh"
// two-stage synchroniser for the four active-low modem pins
module umsil_modem_sync #(
  parameter WIDTH = 4
) (
  input wire core_clk,
  input wire resetn,
  input wire [WIDTH-1:0] pinsN,
  output reg [WIDTH-1:0] syncN_r
);
  reg [WIDTH-1:0] meta_r;
  // reset to inactive (high) so no false change flag after reset
  always @(posedge core_clk) begin
    if (!resetn) begin
      meta_r <= {WIDTH{1'b1}};
      syncN_r <= {WIDTH{1'b1}};
    end else begin
      meta_r <= pinsN;
      syncN_r <= meta_r;
    end
  end
endmodule // umsil_modem_sync

// ==== core/umsil_modem_irq.v ====
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ns
`include "umsil_defines.vh"
module umsil_modem_irq (
  input wire core_clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire cdN,
  input wire riN,
  input wire dsrN,
  input wire ctsN,
  input wire enhancedWrEn,
  input wire fifoEnable,
  input wire lineStatusReq,
  input wire rxTimeoutReq,
  input wire rxDataReq,
  input wire txBelowThresh,
  input wire xoffReq,
  input wire ctsRtsDeassertReq,
  output reg irqOut_r,
  output reg sleepMode_r,
  output reg loopback_r,
  output reg [3:0] modemCtl_r
);
  // pins ordered cd, ri, dsr, cts
  wire [3:0] syncN;
  reg [3:0] prev_r;
  reg [3:0] delta_r;
  reg [7:0] ien_r;
  reg [4:0] mctl_r;
  reg txArmed_r;
  reg txPend_r;
  reg ackDone_r;
  wire [3:0] srcNow;
  wire [3:0] rise;
  wire [3:0] change;
  wire [3:0] flagSet;
  wire busReq;
  wire wrStrobe;
  wire rdStrobe;
  wire loopOn;
  reg [4:0] idCode;
  reg anyPend;
  wire [7:0] statusByte;
  wire [7:0] idByte;

  umsil_modem_sync #(
    .WIDTH(4)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .pinsN({cdN, riN, dsrN, ctsN}),
    .syncN_r(syncN)
  );

  assign loopOn = mctl_r[`UMSIL_MCTL_LOOP];
  // loopback order: cd<-ctl3, ri<-ctl2, dsr<-ctl0, cts<-ctl1
  assign srcNow = loopOn ? {mctl_r[3], mctl_r[2], mctl_r[0], mctl_r[1]}
                         : ~syncN;
  assign change = srcNow ^ prev_r;
  // ring flag: pin going low-to-high (status bit falling); in loopback, status bit rising
  assign rise = loopOn ? (srcNow & ~prev_r) : (~srcNow & prev_r);
  assign flagSet = {change[3], rise[2], change[1], change[0]};

  assign busReq = wb_cyc_i && wb_stb_i && !ackDone_r;
  assign wrStrobe = busReq && wb_we_i && wb_sel_i[0];
  assign rdStrobe = busReq && !wb_we_i && wb_adr_i == `UMSIL_ADR_STATUS;

  always @(posedge core_clk) begin
    if (!resetn) begin
      prev_r <= 4'h0;
      delta_r <= 4'h0;
    end else begin
      prev_r <= srcNow;
      // set beats the clear by read
      delta_r <= (rdStrobe ? 4'h0 : delta_r) | flagSet;
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      ien_r <= `UMSIL_IEN_RESET;
      mctl_r <= `UMSIL_MCTL_RESET;
    end else if (wrStrobe) begin
      if (wb_adr_i == `UMSIL_ADR_IEN) begin
        ien_r[3:0] <= wb_dat_i[3:0];
        if (enhancedWrEn)
          ien_r[7:4] <= wb_dat_i[7:4];
      end
      if (wb_adr_i == `UMSIL_ADR_MCTL)
        mctl_r <= wb_dat_i[4:0];
      // id register address: writes fall through
    end
  end

  // tx interrupt fires only on the threshold edge, not on re-enable
  always @(posedge core_clk) begin
    if (!resetn) begin
      txArmed_r <= 1'b0;
      txPend_r <= 1'b0;
    end else begin
      txArmed_r <= txBelowThresh;
      // disabled source drops its pending state, so re-enable stays quiet
      if (!ien_r[1])
        txPend_r <= 1'b0;
      else if (txBelowThresh && !txArmed_r)
        txPend_r <= 1'b1;
      else if (!txBelowThresh)
        txPend_r <= 1'b0;
    end
  end

  always @* begin
    anyPend = 1'b1;
    idCode = `UMSIL_ID_NONE;
    if (ien_r[2] && lineStatusReq)
      idCode = `UMSIL_ID_LINE;
    else if (ien_r[0] && rxTimeoutReq)
      idCode = `UMSIL_ID_TOUT;
    else if (ien_r[0] && rxDataReq)
      idCode = `UMSIL_ID_RX;
    else if (ien_r[1] && txPend_r)
      idCode = `UMSIL_ID_TX;
    else if (ien_r[3] && |delta_r)
      idCode = `UMSIL_ID_MODEM;
    else if (ien_r[5] && xoffReq)
      idCode = `UMSIL_ID_XOFF;
    else if ((ien_r[7] || ien_r[6]) && ctsRtsDeassertReq)
      idCode = `UMSIL_ID_FLOW;
    else
      anyPend = 1'b0;
  end

  assign statusByte = {srcNow, delta_r};
  assign idByte = {fifoEnable, fifoEnable, idCode, ~anyPend};

  always @(posedge core_clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      ackDone_r <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      ackDone_r <= busReq;
      if (busReq && !wb_we_i) begin
        case (wb_adr_i)
          `UMSIL_ADR_STATUS: wb_dat_o <= {24'h000000, statusByte};
          `UMSIL_ADR_IEN: wb_dat_o <= {24'h000000, ien_r};
          `UMSIL_ADR_ID: wb_dat_o <= {24'h000000, idByte};
          `UMSIL_ADR_MCTL: wb_dat_o <= {27'h0000000, mctl_r};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge core_clk) begin
    if (!resetn) begin
      irqOut_r <= 1'b0;
      sleepMode_r <= 1'b0;
      loopback_r <= 1'b0;
      modemCtl_r <= 4'h0;
    end else begin
      irqOut_r <= anyPend;
      sleepMode_r <= ien_r[4];
      loopback_r <= loopOn;
      modemCtl_r <= mctl_r[3:0];
    end
  end
endmodule // umsil_modem_irq

// ==== tb/umsil_modem_far.sv ====
`timescale 1ns/1ns
module umsil_modem_far (
  input wire [3:0] lineOn,
  output wire cdN,
  output wire riN,
  output wire dsrN,
  output wire ctsN
);
  // lineOn is {cd, ri, dsr, cts} active high; the pins idle high
  assign {cdN, riN, dsrN, ctsN} = ~lineOn;
endmodule // umsil_modem_far

// ==== tb/umsil_modem_irq_props.sv ====
`timescale 1ns/1ns
module umsil_modem_irq_props (
  input wire core_clk,
  input wire resetn,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire enhancedWrEn,
  input wire fifoEnable,
  input wire sleepMode_r,
  input wire loopback_r,
  input wire [3:0] modemCtl_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire rdAck = wb_ack_o && !wb_we_i;
  wire wrAck = wb_ack_o && wb_we_i;
  property p_ack; wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pls; wb_ack_o |=> !wb_ack_o; endproperty
  a_pls: assert property (p_pls) else $error("ack held");
  property p_lpb; wrAck && wb_adr_i == 4'hC
    |=> {loopback_r, modemCtl_r} == $past(wb_dat_i[4:0]); endproperty
  a_lpb: assert property (p_lpb) else $error("ctl write");
  property p_slp; wrAck && wb_adr_i == 4'h4 && enhancedWrEn
    |=> sleepMode_r == $past(wb_dat_i[4]); endproperty
  a_slp: assert property (p_slp) else $error("sleep write");
  property p_lck; wrAck && wb_adr_i == 4'h4 && !enhancedWrEn
    |=> $stable(sleepMode_r); endproperty
  a_lck: assert property (p_lck) else $error("locked bits");
  property p_fen; rdAck && wb_adr_i == 4'h8
    |-> wb_dat_o[7:6] == {2{$past(fifoEnable)}}; endproperty
  a_fen: assert property (p_fen) else $error("id mirror");
  property p_cod; rdAck && wb_adr_i == 4'h8 |-> wb_dat_o[5:1] inside
    {5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h08, 5'h10}; endproperty
  a_cod: assert property (p_cod) else $error("id code");
  property p_lst; rdAck && wb_adr_i == 4'h0 && loopback_r |-> wb_dat_o[7:4]
    == {modemCtl_r[3:2], modemCtl_r[0], modemCtl_r[1]}; endproperty
  a_lst: assert property (p_lst) else $error("loop status");
endmodule // umsil_modem_irq_props

// ==== tb/umsil_modem_irq_test.sv ====
`timescale 1ns/1ns
module umsil_modem_irq_test;
  logic clk = 0, rstN = 0, stb = 0, we = 0, wrEn = 0, fEn = 0;
  logic ack, irq, cdN, riN, dsrN, ctsN;
  logic [3:0] adr = 4'h0, lvl = 4'h0;
  logic [5:0] rq = 6'h00;
  logic [31:0] wd = 32'h00000000, rd;
  logic [7:0] q;
  logic [7:0] idc [6] = '{8'hC6, 8'hCC, 8'hC4, 8'hD0, 8'hE0, 8'hC2};
  int error_cnt = 0, n_compared = 0;
  always #25 clk = ~clk;
  umsil_modem_far umsil_modem_far_inst (.lineOn(lvl), .cdN(cdN),
    .riN(riN), .dsrN(dsrN), .ctsN(ctsN));
  umsil_modem_irq umsil_modem_irq_inst (.core_clk(clk), .resetn(rstN),
    .wb_cyc_i(stb), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .cdN(cdN), .riN(riN), .dsrN(dsrN), .ctsN(ctsN), .enhancedWrEn(wrEn),
    .fifoEnable(fEn), .lineStatusReq(rq[0]), .rxTimeoutReq(rq[1]),
    .rxDataReq(rq[2]), .xoffReq(rq[3]), .ctsRtsDeassertReq(rq[4]),
    .txBelowThresh(rq[5]), .irqOut_r(irq), .sleepMode_r(),
    .loopback_r(), .modemCtl_r());
  task chk(input [7:0] got, input [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task xf(input w, input [3:0] a, input [7:0] d);
    @(posedge clk);
    stb <= 1'b1; we <= w; adr <= a; wd <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rd[7:0];
    stb <= 1'b0;
  endtask
  task rc(input [3:0] a, input [7:0] e);
    xf(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // pins need two sync stages plus a compare before the flag shows
  task settle(input [3:0] l);
    lvl <= l;
    repeat (5) @(posedge clk);
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk);
    rstN <= 1'b1;
    xf(1'b1, 4'h8, 8'hFF);
    rc(4'h8, 8'h01);
    rc(4'h4, 8'h00);
    rc(4'h0, 8'h00);
    rc(4'h2, 8'h00);
    settle(4'h1);
    rc(4'h0, 8'h11);
    rc(4'h0, 8'h10);
    settle(4'h5);
    rc(4'h0, 8'h50);
    settle(4'h1);
    rc(4'h0, 8'h14);
    xf(1'b1, 4'h4, 8'hFF);
    rc(4'h4, 8'h0F);
    wrEn <= 1'b1;
    fEn <= 1'b1;
    xf(1'b1, 4'h4, 8'hEF);
    rc(4'h4, 8'hEF);
    for (int i = 0; i < 6; i++) begin
      rq <= 6'h01 << i;
      repeat (2) @(posedge clk);
      rc(4'h8, idc[i]);
      chk({7'h00, irq}, 8'h01);
    end
    // tx level stays below threshold while the enable is toggled
    xf(1'b1, 4'h4, 8'hED);
    xf(1'b1, 4'h4, 8'hEF);
    rc(4'h8, 8'hC1);
    rq <= 6'h3F;
    rc(4'h8, 8'hC6);
    rq <= 6'h00;
    xf(1'b1, 4'hC, 8'h1F);
    rc(4'h8, 8'hC0);
    rc(4'h0, 8'hFE);
    rc(4'h0, 8'hF0);
    rc(4'h8, 8'hC1);
    end_sim;
  end
endmodule // umsil_modem_irq_test
bind umsil_modem_irq umsil_modem_irq_props umsil_modem_irq_props_inst (.*);
